/* File: rtl/qdac_pkg.sv */
// Constants and carrier types for the quad DAC update/clear control.
// Assumes one 40 MHz clock; all pins synchronous to it.
package qdac_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int CHANNELS   = 4;
    localparam int DATA_BITS  = 14;
    localparam int SHIFT_BITS = 24;
    localparam int CHAN_BITS  = 2;
    localparam int CHAN_LSB   = 16;
    localparam int DATA_LSB   = 0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [DATA_BITS-1:0]  DATA_RESET  = 14'h0000;
    localparam logic [SHIFT_BITS-1:0] SHIFT_RESET = 24'h00_0000;
    localparam logic [4:0]            COUNT_RESET = 5'h00;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic                  serialClock;
        logic                  serialData;
        logic                  serialFrameSyncN;
    } qdac_serial_t;

    typedef struct packed {
        logic                  dacLoadStrobe;
        logic                  forceToSenseGroundN;
    } qdac_ctrl_t;

    typedef enum logic [1:0] {
        QDAC_LIVE    = 2'b01,
        QDAC_GROUNDED = 2'b10
    } qdac_state_t;

endpackage : qdac_pkg

/* File: rtl/qdac_input_regs.sv */
// Four staged input registers, one written per frame.
// Assumes write strobe is one clock wide; read data registered.
`timescale 1ns/1ps
module qdac_input_regs #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 4
) (
    input  wire logic                     clock,
    input  wire logic                     reset_n,
    input  wire logic                     writeEnable,
    input  wire logic [$clog2(DEPTH)-1:0] writeIndex,
    input  wire logic [WIDTH-1:0]         writeData,
    output logic      [DEPTH*WIDTH-1:0]   readAll
);

    logic [WIDTH-1:0] store [DEPTH];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                store[i] <= '0;
            end
        end else if (writeEnable) begin
            store[writeIndex] <= writeData; // R8
        end
    end

    // Registered view so all channels leave together
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readAll <= '0;
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                readAll[i*WIDTH +: WIDTH] <= store[i];
            end
        end
    end

endmodule : qdac_input_regs

/* File: rtl/qdac_update_clear.sv */
// Update and clear control of a four-channel DAC.
// Assumes host pins are synchronous to clock; serial clock is sampled.
//
// Behaviour
// R1 - Strobe high keeps latches unchanged, and outputs too unless clear is low
// R2 - Strobe low copies all four registers together
// R3 - Clear low forces outputs to sense ground
// R4 - After clear release, stay grounded until strobe
// R5 - Strobe low after release reconnects latch levels
// R6 - Clear low ignores load strobe entirely
// R7 - Bits accepted only in frame, 24-bit register
// R8 - Frame sync rise transfers word to input register
`timescale 1ns/1ps
module qdac_update_clear #(
    parameter int CHANNELS  = qdac_pkg::CHANNELS,
    parameter int DATA_BITS = qdac_pkg::DATA_BITS
) (
    input  wire logic                          clock,
    input  wire logic                          reset_n,
    input  wire qdac_pkg::qdac_serial_t        serialIn,
    input  wire qdac_pkg::qdac_ctrl_t          ctrlIn,
    output logic [CHANNELS*DATA_BITS-1:0]      dacLatch,
    output logic                               outputGrounded
);

    // ************************************************************
    // Serial capture
    // ************************************************************
    logic [qdac_pkg::SHIFT_BITS-1:0] shiftReg;
    logic [4:0]                      bitCount;
    logic                            prevSerialClock;
    logic                            prevFrameSyncN;
    logic                            frameEnd;
    logic                            serialRise;
    logic                            wordWrite;
    logic [CHANNELS*DATA_BITS-1:0]   inputRegs;

    assign serialRise = serialIn.serialClock & ~prevSerialClock;
    assign frameEnd   = serialIn.serialFrameSyncN & ~prevFrameSyncN;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prevSerialClock <= 1'b0;
            prevFrameSyncN  <= 1'b1;
        end else begin
            prevSerialClock <= serialIn.serialClock;
            prevFrameSyncN  <= serialIn.serialFrameSyncN;
        end
    end

    // Extra bits push the oldest out; only the last 24 count
    // Bits outside a frame are dropped, not shifted
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shiftReg <= qdac_pkg::SHIFT_RESET;
            bitCount <= qdac_pkg::COUNT_RESET;
        end else if (serialIn.serialFrameSyncN) begin
            bitCount <= qdac_pkg::COUNT_RESET;
        end else if (serialRise) begin // R7
            shiftReg <= {shiftReg[qdac_pkg::SHIFT_BITS-2:0],
                         serialIn.serialData};
            if (bitCount != 5'h18) begin
                bitCount <= bitCount + 5'h01;
            end
        end
    end

    // Short frames are still transferred; the host owns word length
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wordWrite <= 1'b0;
        end else begin
            wordWrite <= frameEnd; // R8
        end
    end

    logic [qdac_pkg::SHIFT_BITS-1:0] heldWord;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            heldWord <= qdac_pkg::SHIFT_RESET;
        end else if (frameEnd) begin
            heldWord <= shiftReg; // R8
        end
    end

    qdac_input_regs #(
        .WIDTH (DATA_BITS),
        .DEPTH (CHANNELS)
    ) u_input_regs (
        .clock       (clock),
        .reset_n     (reset_n),
        .writeEnable (wordWrite),
        .writeIndex  (heldWord[qdac_pkg::CHAN_LSB +: qdac_pkg::CHAN_BITS]),
        .writeData   (heldWord[qdac_pkg::DATA_LSB +: DATA_BITS]),
        .readAll     (inputRegs)
    );

    // ************************************************************
    // Latch update and clear
    // ************************************************************
    qdac_pkg::qdac_state_t state;
    qdac_pkg::qdac_state_t next_state;
    logic                  loadNow;

    // Clear is sampled like every other pin; a clear pulse shorter
    // than one clock period can be missed
    // Clear masks the strobe completely
    assign loadNow = ctrlIn.dacLoadStrobe == 1'b0
                   && ctrlIn.forceToSenseGroundN; // R6

    always_comb begin
        next_state = state;
        unique case (state)
            qdac_pkg::QDAC_LIVE: begin
                if (!ctrlIn.forceToSenseGroundN) begin
                    next_state = qdac_pkg::QDAC_GROUNDED; // R3
                end
            end
            qdac_pkg::QDAC_GROUNDED: begin
                if (loadNow) begin
                    next_state = qdac_pkg::QDAC_LIVE; // R5
                end
            end
            default: next_state = qdac_pkg::QDAC_GROUNDED;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= qdac_pkg::QDAC_GROUNDED;
        end else begin
            state <= next_state; // R4
        end
    end

    // Grounding also follows the clear pin at once, not the state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            outputGrounded <= 1'b1;
        end else begin
            outputGrounded <= !ctrlIn.forceToSenseGroundN
                           || next_state == qdac_pkg::QDAC_GROUNDED; // R3
        end
    end

    // Level-sensitive load: latches track input regs while low
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dacLatch <= '0;
        end else if (loadNow) begin
            dacLatch <= inputRegs; // R2
        end
    end // R1

    // ************************************************************
    // Checks
    // ************************************************************
    // Each check looks one edge after its cause: all outputs are registered
    AST_HOLD_WHEN_HIGH: assert property ( // R1
        @(posedge clock) disable iff (!reset_n)
        ctrlIn.dacLoadStrobe |=> $stable(dacLatch))
        else $error("Latch changed with strobe high");
    AST_LOAD_ALL: assert property ( // R2
        @(posedge clock) disable iff (!reset_n)
        loadNow |=> dacLatch == $past(inputRegs))
        else $error("Latch missed load");
    AST_CLEAR_GROUND: assert property ( // R3
        @(posedge clock) disable iff (!reset_n)
        !ctrlIn.forceToSenseGroundN |=> outputGrounded)
        else $error("Output not grounded in clear");
    AST_STAY_GROUND: assert property ( // R4
        @(posedge clock) disable iff (!reset_n)
        (outputGrounded && ctrlIn.dacLoadStrobe) |=> outputGrounded)
        else $error("Ground released without strobe");
    AST_ARM_GROUND: assert property ( // R4
        @(posedge clock) disable iff (!reset_n)
        !ctrlIn.forceToSenseGroundN |=> state == qdac_pkg::QDAC_GROUNDED)
        else $error("Clear did not arm grounded state");
    AST_RECONNECT: assert property ( // R5
        @(posedge clock) disable iff (!reset_n)
        loadNow |=> !outputGrounded)
        else $error("Output not reconnected");
    AST_STAY_LIVE: assert property ( // R5
        @(posedge clock) disable iff (!reset_n)
        state == qdac_pkg::QDAC_LIVE && ctrlIn.forceToSenseGroundN
        |=> !outputGrounded)
        else $error("Live output grounded without clear");
    AST_IGNORE_STROBE: assert property ( // R6
        @(posedge clock) disable iff (!reset_n)
        !ctrlIn.forceToSenseGroundN |=> $stable(dacLatch))
        else $error("Strobe acted during clear");
    AST_NO_SHIFT_IDLE: assert property ( // R7
        @(posedge clock) disable iff (!reset_n)
        serialIn.serialFrameSyncN && prevFrameSyncN |=> $stable(shiftReg))
        else $error("Shift outside frame");
    AST_SHIFT_IN_FRAME: assert property ( // R7
        @(posedge clock) disable iff (!reset_n)
        !serialIn.serialFrameSyncN && serialRise
        |=> shiftReg[0] == $past(serialIn.serialData))
        else $error("Framed bit not shifted in");
    AST_COUNT_RESTART: assert property ( // R7
        @(posedge clock) disable iff (!reset_n)
        serialIn.serialFrameSyncN |=> bitCount == qdac_pkg::COUNT_RESET)
        else $error("Bit count kept outside frame");
    AST_FRAME_WRITE: assert property ( // R8
        @(posedge clock) disable iff (!reset_n)
        frameEnd |=> wordWrite && heldWord == $past(shiftReg))
        else $error("Frame end not transferred");
    AST_WRITE_AT_END_ONLY: assert property ( // R8
        @(posedge clock) disable iff (!reset_n)
        !frameEnd |=> !wordWrite)
        else $error("Input register written without frame end");

    // ************************************************************
    // Scenario covers
    // ************************************************************
    COV_LOAD: cover property (@(posedge clock) disable iff (!reset_n)
        wordWrite ##[1:20] loadNow);
    COV_CLEAR_RELEASE: cover property (@(posedge clock) disable iff (!reset_n)
        !ctrlIn.forceToSenseGroundN ##1 ctrlIn.forceToSenseGroundN
        ##[1:20] loadNow);
    COV_FULL_FRAME: cover property (@(posedge clock) disable iff (!reset_n)
        bitCount == 5'h18 ##[1:10] frameEnd);
    COV_MASKED_STROBE: cover property (@(posedge clock) disable iff (!reset_n)
        !ctrlIn.forceToSenseGroundN && !ctrlIn.dacLoadStrobe && wordWrite);
    COV_STRAY_CLOCK: cover property (@(posedge clock) disable iff (!reset_n)
        serialIn.serialFrameSyncN && serialRise);

endmodule : qdac_update_clear

/* File: sim/qdac_host_model.sv */
// Host model: frames 24-bit words onto the serial pins of the DAC control.
// Assumes the bench calls sendWord; serial clock idles outside frames,
// except in strayClocks, which drives such pulses for the block to drop.
`timescale 1ns/1ps
module qdac_host_model (
    input  wire logic             clock,
    output qdac_pkg::qdac_serial_t serialOut
);
    // ************************************************************
    // Idle pins
    // ************************************************************
    initial begin
        serialOut.serialClock      = 1'b0;
        serialOut.serialData       = 1'b1;
        serialOut.serialFrameSyncN = 1'b1;
    end

    // ************************************************************
    // One frame, MSB first, two clocks per serial phase
    // ************************************************************
    task automatic sendWord(input logic [23:0] word);
        @(posedge clock);
        #1;
        serialOut.serialFrameSyncN = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            serialOut.serialClock = 1'b0;
            serialOut.serialData  = word[i];
            repeat (2) @(posedge clock);
            #1;
            serialOut.serialClock = 1'b1;
            repeat (2) @(posedge clock);
            #1;
        end
        serialOut.serialClock = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        serialOut.serialFrameSyncN = 1'b1;
        // Released line shows the inverse so a stale bit never looks valid
        serialOut.serialData = ~word[0];
    endtask : sendWord

    // ************************************************************
    // Clock pulses with the frame closed; none may be shifted in
    // ************************************************************
    task automatic strayClocks(input int count);
        for (int i = 0; i < count; i++) begin
            serialOut.serialClock = 1'b1;
            serialOut.serialData  = ~serialOut.serialData;
            repeat (2) @(posedge clock);
            #1;
            serialOut.serialClock = 1'b0;
            repeat (2) @(posedge clock);
            #1;
        end
    endtask : strayClocks
endmodule : qdac_host_model

/* File: sim/tb.sv */
// Testbench for the quad DAC update/clear control.
// Assumes qdac_pkg compiled first; host model drives the serial pins.
`timescale 1ns/1ps
module tb;
    logic                   clock;
    logic                   reset_n;
    qdac_pkg::qdac_serial_t serial;
    qdac_pkg::qdac_ctrl_t   ctrl;
    logic [55:0]            dacLatch;
    logic                   outputGrounded;
    logic [55:0]            expVec;
    int                     errorCnt;
    int                     checked;

    qdac_host_model host_u (.clock(clock), .serialOut(serial));
    qdac_update_clear dut_u (
        .clock         (clock),
        .reset_n       (reset_n),
        .serialIn      (serial),
        .ctrlIn        (ctrl),
        .dacLatch      (dacLatch),
        .outputGrounded(outputGrounded)
    );

    always #12.5 clock = ~clock;

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic cmpVec(input logic [55:0] got, input logic [55:0] exp);
        checked++;
        if (got !== exp) begin
            errorCnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpVec
    task automatic cmpBit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            errorCnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpBit
    task automatic setCtrl(input logic strobe, input logic clearN);
        @(posedge clock);
        #1;
        ctrl.dacLoadStrobe       = strobe;
        ctrl.forceToSenseGroundN = clearN;
    endtask : setCtrl
    // Bounded wait; running out counts a mismatch and ends the run
    task automatic waitLatch(input logic [55:0] old);
        int n;
        n = 0;
        while (n < 12 && dacLatch === old) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (dacLatch === old) begin
            errorCnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, dacLatch, expVec);
            endSim();
        end
    endtask : waitLatch
    task automatic writeChan(input logic [1:0] ch, input logic [13:0] d);
        host_u.sendWord({6'h00, ch, 2'b00, d});
        expVec[ch*14 +: 14] = d;
        // Strobe must not be lowered before the word settles in its register
        repeat (5) @(posedge clock);
        #1;
    endtask : writeChan
    task automatic endSim;
        $display("errors %0d, comparisons %0d", errorCnt, checked);
        if (errorCnt == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : endSim

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic testLoad;
        logic [55:0] old;
        old = dacLatch;
        host_u.strayClocks(3);
        for (int c = 0; c < 4; c++) writeChan(c[1:0], 14'h3FFF - 14'(c * 3));
        cmpVec(dacLatch, old);
        cmpBit(outputGrounded, 1'b1);
        setCtrl(1'b0, 1'b1);
        waitLatch(old);
        cmpVec(dacLatch, expVec);
        @(posedge clock);
        #1;
        cmpBit(outputGrounded, 1'b0);
        setCtrl(1'b1, 1'b1);
    endtask : testLoad
    task automatic testClear;
        logic [55:0] old;
        old = dacLatch;
        setCtrl(1'b1, 1'b0);
        repeat (3) @(posedge clock);
        #1;
        cmpBit(outputGrounded, 1'b1);
        setCtrl(1'b0, 1'b0);
        writeChan(2'b10, 14'h2A55);
        writeChan(2'b00, 14'h0001);
        cmpVec(dacLatch, old);
        cmpBit(outputGrounded, 1'b1);
        setCtrl(1'b1, 1'b1);
        repeat (6) @(posedge clock);
        #1;
        cmpBit(outputGrounded, 1'b1);
        cmpVec(dacLatch, old);
        setCtrl(1'b0, 1'b1);
        waitLatch(old);
        cmpVec(dacLatch, expVec);
        @(posedge clock);
        #1;
        cmpBit(outputGrounded, 1'b0);
    endtask : testClear

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        clock    = 1'b0;
        reset_n  = 1'b0;
        ctrl.dacLoadStrobe       = 1'b1;
        ctrl.forceToSenseGroundN = 1'b1;
        expVec   = 56'h00_0000_0000_0000;
        errorCnt = 0;
        checked  = 0;
        repeat (16) @(posedge clock);
        #1;
        reset_n = 1'b1;
        cmpVec(dacLatch, 56'h00_0000_0000_0000);
        cmpBit(outputGrounded, 1'b1);
        testLoad();
        testClear();
        endSim();
    end
endmodule : tb
